// *** rtl/bpsc_decode.sv ***
/*
  Maps a seven-bit voltage code (range bit plus six-bit set point) to a
  target in millivolts, and flags targets the regulator cannot produce.
  Purely combinational; the caller registers the results.
*/
module bpsc_decode (
  input wire logic [6:0] code,
  output logic [11:0] target_mv,
  output logic unsupported
);
  wire logic [11:0] low_mv;
  wire logic [11:0] high_mv;

  assign low_mv = 12'(bpsc_pkg::LOW_BASE_MV + 12'(code[5:0]) * bpsc_pkg::LOW_STEP_MV);
  assign high_mv = 12'(bpsc_pkg::HIGH_BASE_MV + 12'(code[5:0]) * bpsc_pkg::HIGH_STEP_MV);
  assign target_mv = code[6] ? high_mv : low_mv;
  // Hardware only reports such a target; keeping clear of it is up to software.
  assign unsupported = (target_mv <= bpsc_pkg::MIN_SUPPORTED_MV);
endmodule : bpsc_decode

// *** rtl/bpsc_pkg.sv ***
/*
  Constants shared by the buck pair set-point control block: register offsets,
  field positions, reset values, decode codes and voltage scale figures.
  Assumes a Wishbone classic slave with 32-bit data and byte addressing.
*/
package bpsc_pkg;
  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] A_NORMAL_OFF = 8'h00;
  localparam logic [7:0] A_STANDBY_OFF = 8'h04;
  localparam logic [7:0] A_SLEEP_OFF = 8'h08;
  localparam logic [7:0] B_NORMAL_OFF = 8'h10;
  localparam logic [7:0] B_STANDBY_OFF = 8'h14;
  localparam logic [7:0] B_SLEEP_OFF = 8'h18;
  localparam logic [7:0] CONTROL_OFF = 8'h20;
  localparam logic [7:0] STATUS_OFF = 8'h24;
  localparam logic [7:0] TARGET_A_OFF = 8'h28;
  localparam logic [7:0] TARGET_B_OFF = 8'h2c;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int SETPOINT_MSB = 5;
  localparam int RANGE_BIT = 6;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam logic [5:0] SETPOINT_RST = 6'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  // Count of edges after reset release before the synchronised straps are taken.
  localparam logic [1:0] STRAP_LATCH_CNT = 2'h2;

  // ------------------------------------------------------------------
  // Pair configuration codes
  // ------------------------------------------------------------------
  localparam logic [1:0] CFG_SINGLE0 = 2'h0;
  localparam logic [1:0] CFG_SINGLE1 = 2'h1;
  localparam logic [1:0] CFG_RESERVED = 2'h2;
  localparam logic [1:0] CFG_INDEP = 2'h3;

  // ------------------------------------------------------------------
  // Voltage scale in millivolts
  // ------------------------------------------------------------------
  localparam logic [11:0] LOW_BASE_MV = 12'h190;
  localparam logic [11:0] LOW_STEP_MV = 12'h019;
  localparam logic [11:0] HIGH_BASE_MV = 12'h320;
  localparam logic [11:0] HIGH_STEP_MV = 12'h032;
  localparam logic [11:0] MIN_SUPPORTED_MV = 12'h258;

  typedef enum logic [1:0] {
    BPSC_NORMAL,
    BPSC_STANDBY,
    BPSC_SLEEP
  } bpsc_mode_t;
endpackage : bpsc_pkg

// *** rtl/bpsc_top.sv ***
/*
  Set-point and configuration control for a pair of buck regulators with a
  Wishbone classic register slave. Assumes one clock, asynchronous active-low
  reset, and pair configuration and range bits that stay static from OTP pins.
*/
module bpsc_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] pair_phase_config,
  input wire logic range_a,
  input wire logic range_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic [6:0] code_a_r,
  output logic [6:0] code_b_r,
  output logic [11:0] target_a_mv_r,
  output logic [11:0] target_b_mv_r,
  output logic single_phase_r,
  output logic config_reserved_r
);
  // ------------------------------------------------------------------
  // Pin synchronisers and strap capture
  // ------------------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic strap_done_r;
  logic [1:0] strap_cnt_r;
  logic [1:0] cfg_r;
  logic range_a_r;
  logic range_b_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {range_b, range_a, pair_phase_config};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Straps are latched once, at the third edge after reset, when the second
  // synchroniser stage holds the pin value; later pin motion is ignored so the
  // range cannot change under a running regulator.
  wire logic strap_now;
  assign strap_now = !strap_done_r && (strap_cnt_r == bpsc_pkg::STRAP_LATCH_CNT);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_cnt_r <= 2'h0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= 2'(strap_cnt_r + 2'h1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_done_r <= 1'b0;
      cfg_r <= bpsc_pkg::CFG_SINGLE0;
      range_a_r <= 1'b0;
      range_b_r <= 1'b0;
    end else if (strap_now) begin
      strap_done_r <= 1'b1;
      cfg_r <= pin_s2_r[1:0];
      range_a_r <= pin_s2_r[2];
      range_b_r <= pin_s2_r[3];
    end
  end

  // ------------------------------------------------------------------
  // Configuration decode
  // ------------------------------------------------------------------
  wire logic single_phase;
  wire logic reserved_cfg;
  assign single_phase = (cfg_r == bpsc_pkg::CFG_SINGLE0) || (cfg_r == bpsc_pkg::CFG_SINGLE1);
  assign reserved_cfg = (cfg_r == bpsc_pkg::CFG_RESERVED);

  // ------------------------------------------------------------------
  // Wishbone decode
  // ------------------------------------------------------------------
  wire logic req;
  wire logic wr;
  wire logic lane0;
  wire logic [8:0] hit;
  wire logic mapped;
  logic [5:0] sp_r [6];
  logic [1:0] mode_r;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr = req && wb_we_i;
  assign lane0 = wb_sel_i[0];
  assign hit[0] = (wb_adr_i == bpsc_pkg::A_NORMAL_OFF);
  assign hit[1] = (wb_adr_i == bpsc_pkg::A_STANDBY_OFF);
  assign hit[2] = (wb_adr_i == bpsc_pkg::A_SLEEP_OFF);
  assign hit[3] = (wb_adr_i == bpsc_pkg::B_NORMAL_OFF);
  assign hit[4] = (wb_adr_i == bpsc_pkg::B_STANDBY_OFF);
  assign hit[5] = (wb_adr_i == bpsc_pkg::B_SLEEP_OFF);
  assign hit[6] = (wb_adr_i == bpsc_pkg::CONTROL_OFF);
  assign hit[7] = (wb_adr_i == bpsc_pkg::STATUS_OFF);
  assign hit[8] = (wb_adr_i == bpsc_pkg::TARGET_A_OFF) || (wb_adr_i == bpsc_pkg::TARGET_B_OFF);
  assign mapped = |hit;

  // ------------------------------------------------------------------
  // Set-point registers
  // ------------------------------------------------------------------
  // Three writable set points each.
  for (genvar i = 0; i < 6; i++) begin : g_sp
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        sp_r[i] <= bpsc_pkg::SETPOINT_RST;
      end else if (wr && lane0 && hit[i]) begin
        sp_r[i] <= wb_dat_i[bpsc_pkg::SETPOINT_MSB:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= bpsc_pkg::MODE_RST;
    end else if (wr && lane0 && hit[6] && wb_dat_i[1:0] != 2'h3) begin
      mode_r <= wb_dat_i[bpsc_pkg::MODE_MSB:bpsc_pkg::MODE_LSB];
    end
  end

  // ------------------------------------------------------------------
  // Set-point selection
  // ------------------------------------------------------------------
  wire logic [2:0] sel_idx;
  wire logic [6:0] code_a;
  wire logic [6:0] code_b;
  wire logic [11:0] mv_a;
  wire logic [11:0] mv_b;
  wire logic uns_a;
  wire logic uns_b;

  assign sel_idx = {1'b0, mode_r};
  // All modes share the strapped range.
  // Single phase runs both from A.
  assign code_a = {range_a_r, sp_r[sel_idx]};
  assign code_b = single_phase ? code_a : {range_b_r, sp_r[3'(sel_idx + 3'h3)]};

  bpsc_decode u_dec_a (
    .code(code_a),
    .target_mv(mv_a),
    .unsupported(uns_a)
  );

  bpsc_decode u_dec_b (
    .code(code_b),
    .target_mv(mv_b),
    .unsupported(uns_b)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_a_r <= 7'h00;
      code_b_r <= 7'h00;
      target_a_mv_r <= bpsc_pkg::LOW_BASE_MV;
      target_b_mv_r <= bpsc_pkg::LOW_BASE_MV;
      single_phase_r <= 1'b1;
      config_reserved_r <= 1'b0;
    end else begin
      code_a_r <= code_a;
      code_b_r <= code_b;
      target_a_mv_r <= mv_a;
      target_b_mv_r <= mv_b;
      single_phase_r <= single_phase;
      config_reserved_r <= reserved_cfg;
    end
  end

  // ------------------------------------------------------------------
  // Read data and answer
  // ------------------------------------------------------------------
  wire logic [2:0] rd_idx;
  wire logic [31:0] rd_sp;
  wire logic [31:0] rd_data;
  wire logic range_of_idx;

  assign rd_idx = hit[0] ? 3'h0 : hit[1] ? 3'h1 : hit[2] ? 3'h2 :
                  hit[3] ? 3'h3 : hit[4] ? 3'h4 : 3'h5;
  assign range_of_idx = (rd_idx < 3'h3) ? range_a_r : range_b_r;
  // Range bit shows in every set-point register.
  assign rd_sp = {25'h0, range_of_idx, sp_r[rd_idx]};
  assign rd_data = (|hit[5:0]) ? rd_sp :
                   hit[6] ? {30'h0, mode_r} :
                   hit[7] ? {26'h0, uns_b, uns_a, reserved_cfg, single_phase, cfg_r} :
                   (wb_adr_i == bpsc_pkg::TARGET_A_OFF) ? {20'h0, target_a_mv_r} :
                   {20'h0, target_b_mv_r};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      wb_dat_o <= (req && mapped && !wb_we_i) ? rd_data : 32'h0;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  // Targets are held against literal figures, not the decoder's own expression,
  // so a wrong step or base constant in the package shows up here.
  a_single_mirror: assert property (@(posedge clk) disable iff (!rstn)
    single_phase_r |-> code_b_r == code_a_r)
    else $error("single phase output B differs from A");
  a_cfg_decode: assert property (@(posedge clk) disable iff (!rstn)
    strap_done_r |=> single_phase_r == !cfg_r[1])
    else $error("pair configuration decode wrong");
  a_range_fixed: assert property (@(posedge clk) disable iff (!rstn)
    strap_done_r && wr |=> $stable(range_a_r) && $stable(range_b_r))
    else $error("range bit changed by a write");
  a_low_step: assert property (@(posedge clk) disable iff (!rstn)
    !code_a_r[6] |-> target_a_mv_r == 12'(12'd400 + 12'(code_a_r[5:0]) * 12'd25))
    else $error("low range target wrong");
  a_high_step: assert property (@(posedge clk) disable iff (!rstn)
    code_a_r[6] |-> target_a_mv_r == 12'(12'd800 + 12'(code_a_r[5:0]) * 12'd50))
    else $error("high range target wrong");
  a_mode_select: assert property (@(posedge clk) disable iff (!rstn)
    ##1 code_a_r[5:0] == $past(sp_r[sel_idx]))
    else $error("set point not from current mode");
  a_range_shared: assert property (@(posedge clk) disable iff (!rstn)
    req && !wb_we_i && hit[1] |=> wb_dat_o[6] == range_a_r)
    else $error("standby range bit differs");
  a_indep_own: assert property (@(posedge clk) disable iff (!rstn)
    !single_phase |=> code_b_r[5:0] == $past(sp_r[3'(sel_idx + 3'h3)]))
    else $error("independent B not from own registers");
  a_code_map: assert property (@(posedge clk) disable iff (!rstn)
    code_b_r == 7'h40 |-> target_b_mv_r == 12'd800)
    else $error("code 1000000 not 0.8 V");
  a_reserved_flag: assert property (@(posedge clk) disable iff (!rstn)
    strap_done_r |=> config_reserved_r == (cfg_r == bpsc_pkg::CFG_RESERVED))
    else $error("reserved configuration flag wrong");
  a_reserved_indep: assert property (@(posedge clk) disable iff (!rstn)
    config_reserved_r |-> !single_phase_r)
    else $error("reserved configuration runs single phase");
  a_b_low_step: assert property (@(posedge clk) disable iff (!rstn)
    !code_b_r[6] |-> target_b_mv_r == 12'(12'd400 + 12'(code_b_r[5:0]) * 12'd25))
    else $error("low range target B wrong");
  a_b_high_step: assert property (@(posedge clk) disable iff (!rstn)
    code_b_r[6] |-> target_b_mv_r == 12'(12'd800 + 12'(code_b_r[5:0]) * 12'd50))
    else $error("high range target B wrong");
  a_normal_range: assert property (@(posedge clk) disable iff (!rstn)
    req && !wb_we_i && hit[0] |=> wb_dat_o[6] == range_a_r)
    else $error("normal range bit reads wrong");
  a_sleep_range: assert property (@(posedge clk) disable iff (!rstn)
    req && !wb_we_i && hit[5] |=> wb_dat_o[6] == range_b_r)
    else $error("sleep range bit differs");
  a_code_range: assert property (@(posedge clk) disable iff (!rstn)
    strap_done_r |=> code_a_r[6] == range_a_r)
    else $error("applied range A not the strapped one");
  a_b_own_range: assert property (@(posedge clk) disable iff (!rstn)
    strap_done_r && !single_phase |=> code_b_r[6] == range_b_r)
    else $error("independent B range not its own");
  a_mode_legal: assert property (@(posedge clk) disable iff (!rstn)
    mode_r != 2'h3)
    else $error("mode register holds an illegal value");
  a_sp_write: assert property (@(posedge clk) disable iff (!rstn)
    wr && lane0 && hit[1] |=> sp_r[1] == $past(wb_dat_i[5:0]))
    else $error("standby set point not written");
  a_mode_write: assert property (@(posedge clk) disable iff (!rstn)
    wr && lane0 && hit[6] && wb_dat_i[1:0] != 2'h3 |=> mode_r == $past(wb_dat_i[1:0]))
    else $error("mode not written");
  a_code_zero: assert property (@(posedge clk) disable iff (!rstn)
    code_a_r == 7'h00 |-> target_a_mv_r == 12'd400)
    else $error("code 0000000 not 0.4 V");

  // ------------------------------------------------------------------
  // Cover properties
  // ------------------------------------------------------------------
  c_write: cover property (@(posedge clk) disable iff (!rstn) wr && hit[0]);
  c_read: cover property (@(posedge clk) disable iff (!rstn) req && !wb_we_i && hit[7]);
  c_indep: cover property (@(posedge clk) disable iff (!rstn) !single_phase_r);
  c_err: cover property (@(posedge clk) disable iff (!rstn) wb_err_o);
  c_reserved: cover property (@(posedge clk) disable iff (!rstn) config_reserved_r);
endmodule : bpsc_top

// *** test/bpsc_top_tb.sv ***
/*
  Self-checking bench for bpsc_top: straps, set-point registers, mode selection
  and Wishbone errors. Assumes the bench alone drives every port of the block.
*/
module bpsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, range_a, range_b, cyc, stb, we, ack, err, single, resv;
  logic [1:0] cfg;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, q;
  logic [6:0] code_a, code_b;
  logic [11:0] tgt_a, tgt_b;
  logic e;
  int bad_count, n_tests;

  bpsc_top dut (.clk(clk), .rstn(rstn), .pair_phase_config(cfg), .range_a(range_a),
    .range_b(range_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .wb_err_o(err),
    .code_a_r(code_a), .code_b_r(code_b), .target_a_mv_r(tgt_a), .target_b_mv_r(tgt_b),
    .single_phase_r(single), .config_reserved_r(resv));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Ack is registered: the request stands until the rising edge at which ack
  // or err is sampled high; data is taken there and only then released.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1 && err !== 1'b1);
    q = dr;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
    repeat (2) @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(q, exp);
  endtask : rd

  function automatic logic [31:0] mv(input logic [6:0] c);
    return c[6] ? 32'd800 + 32'd50 * c[5:0] : 32'd400 + 32'd25 * c[5:0];
  endfunction : mv

  task automatic rst(input logic [1:0] c, input logic ra, input logic rb);
    @(posedge clk);
    rstn <= 1'b0;
    cfg <= c;
    range_a <= ra;
    range_b <= rb;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(negedge clk);
  endtask : rst

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_straps;
    rst(2'h3, 1'b0, 1'b1);
    chk(single, 1'b0);
    chk(resv, 1'b0);
    rd(bpsc_pkg::STATUS_OFF, 32'h13);
    rd(bpsc_pkg::A_NORMAL_OFF, 32'h0);
    rd(bpsc_pkg::B_NORMAL_OFF, 32'h40);
    rd(bpsc_pkg::B_STANDBY_OFF, 32'h40);
    rd(bpsc_pkg::B_SLEEP_OFF, 32'h40);
  endtask : t_straps

  task automatic t_range;
    wr(bpsc_pkg::A_NORMAL_OFF, 32'h7f);
    rd(bpsc_pkg::A_NORMAL_OFF, 32'h3f);
    chk(code_a, 7'h3f);
    chk(tgt_a, 12'd1975);
    wr(bpsc_pkg::B_NORMAL_OFF, 32'h32);
    chk(code_b, 7'h72);
    chk(tgt_b, 12'd3300);
    chk(code_a, 7'h3f);
  endtask : t_range

  task automatic t_modes;
    logic [6:0] ea [4];
    logic [6:0] eb [4];
    ea = '{7'h3f, 7'h0a, 7'h14, 7'h14};
    eb = '{7'h72, 7'h40, 7'h40, 7'h40};
    wr(bpsc_pkg::A_STANDBY_OFF, 32'h0a);
    wr(bpsc_pkg::A_SLEEP_OFF, 32'h14);
    for (int m = 0; m < 4; m++) begin
      wr(bpsc_pkg::CONTROL_OFF, m);
      chk(code_a, ea[m]);
      chk(code_b, eb[m]);
      rd(bpsc_pkg::TARGET_A_OFF, mv(ea[m]));
    end
    wr(bpsc_pkg::CONTROL_OFF, 32'h0);
  endtask : t_modes

  task automatic t_bus;
    wb(1'b0, 8'h30, 32'h0, 4'hf);
    chk(e, 1'b1);
    wb(1'b1, bpsc_pkg::A_NORMAL_OFF, 32'h21, 4'he);
    rd(bpsc_pkg::A_NORMAL_OFF, 32'h3f);
    wr(bpsc_pkg::TARGET_A_OFF, 32'hfff);
    rd(bpsc_pkg::TARGET_A_OFF, 32'd1975);
  endtask : t_bus

  task automatic t_single;
    for (int c = 0; c < 3; c++) begin
      rst(c[1:0], 1'b0, 1'b1);
      chk(single, c != 2);
      chk(resv, c == 2);
      wr(bpsc_pkg::A_NORMAL_OFF, 32'h20);
      wr(bpsc_pkg::B_NORMAL_OFF, 32'h20);
      chk(code_a, 7'h20);
      chk(code_b, c != 2 ? 7'h20 : 7'h60);
      chk(tgt_b, c != 2 ? 12'd1200 : 12'd2400);
    end
  endtask : t_single

  initial begin
    rstn = 1'b0; cfg = 2'h3; range_a = 1'b0; range_b = 1'b1;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; dw = 32'h0;
    bad_count = 0;
    n_tests = 0;
    t_straps();
    t_range();
    t_modes();
    t_bus();
    t_single();
    summarize();
  end

  // The whole run needs well under 2000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule : bpsc_top_tb
